// >>> bench/sdram_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Controller stand-in
// ****************
module sdram_ctrl_model (
  input  wire logic        clk_i,
  output logic             cke_o,
  output logic [3:0]       cmd_o,
  output logic [1:0]       ba_o,
  output logic [11:0]      addr_o,
  output logic [15:0]      dq_o,
  output logic [1:0]       dqm_o
);
  initial begin
    cke_o = 1'b1;
    cmd_o = 4'hf;
    ba_o = 2'h0;
    addr_o = 12'h0;
    dq_o = 16'h0;
    dqm_o = 2'h0;
  end
  // One command, then deselect; released address flips so stale values never match
  task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
    @(posedge clk_i);
    cmd_o <= {1'b0, c};
    ba_o <= b;
    addr_o <= a;
    @(posedge clk_i);
    cmd_o <= 4'hf;
    addr_o <= ~a;
  endtask : issue
  // Data one edge after the command, one word per edge
  task automatic write(input logic [1:0] b, input logic [11:0] a, input int n,
                       input logic [15:0] d, input logic [1:0] mask);
    issue(3'b100, b, a);
    for (int i = 0; i < n; i++) begin
      dq_o <= d + 16'(i);
      dqm_o <= mask;
      @(posedge clk_i);
    end
    dq_o <= ~dq_o;
    dqm_o <= 2'h0;
  endtask : write
  task automatic set_cke(input logic v);
    cke_o <= v;
  endtask : set_cke
  // Banks closed before enable drops
  task automatic power_down;
    issue(3'b010, 2'h0, 12'h400);
    cke_o <= 1'b0;
  endtask : power_down
  task automatic self_refresh;
    issue(3'b010, 2'h0, 12'h400);
    @(posedge clk_i);
    cmd_o <= 4'b0001;
    cke_o <= 1'b0;
    @(posedge clk_i);
    cmd_o <= 4'hf;
  endtask : self_refresh
endmodule : sdram_ctrl_model
`default_nettype wire

// >>> bench/tb_sdram_clock_enable_burst_front_end.sv
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_clock_enable_burst_front_end;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [1:0]  dqm;
  logic [31:0] wdat = 32'h0, wb_dat_o, rdat;
  logic        wb_ack_o, dq_oe_o, cke;
  logic [3:0]  cmd;
  logic [1:0]  ba;
  logic [11:0] addr;
  logic [15:0] dq_i, dq_o, cnt;
  int          err_total = 0, comparisons = 0;
  // ****************
  // Clock, design, partner
  // ****************
  initial forever #5 clk_i = ~clk_i;
  sdram_front_end #(.ROW_W(11), .COL_W(9)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr[10:0]),
    .dqm_i(dqm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  sdram_ctrl_model m (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba),
    .addr_o(addr), .dq_o(dq_i), .dqm_o(dqm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // A missing answer counts against the run
    if (wb_ack_o !== 1'b1) err_total++;
    q = wb_dat_o;
    cyc <= 1'b0;
  endtask : wb
  // Read burst on bank 1, words expected to hold a000 plus column
  task automatic rd_chk(input logic [8:0] a, input int cl, input int bl, input logic il);
    logic [8:0] c;
    m.issue(3'b101, 2'h1, {3'h0, a});
    repeat (cl) @(posedge clk_i);
    for (int i = 0; i < bl; i++) begin
      c = il ? (a ^ 9'(i)) : ((a & ~9'(bl - 1)) | ((a + 9'(i)) & 9'(bl - 1)));
      #1 chk({dq_oe_o, 15'h0, dq_o}, {1'b1, 15'h0, 16'ha000 + 16'(c)});
      @(posedge clk_i);
    end
    #1 chk(32'(dq_oe_o), 32'h0);
  endtask : rd_chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, rdat); chk(rdat, 32'h20);
    // Mode write with lane 0 off must leave the mode alone
    sel <= 4'h0;
    wb(1'b1, 8'h00, 32'h33, rdat);
    sel <= 4'hf;
    wb(1'b0, 8'h00, 32'h0, rdat); chk(rdat, 32'h20);
    wb(1'b1, 8'h08, 32'hff, rdat);
    wb(1'b0, 8'h08, 32'h0, rdat); chk(rdat, 32'h0);
    m.issue(3'b101, 2'h1, 12'h000);
    repeat (5) @(posedge clk_i);
    #1 chk(32'(dq_oe_o), 32'h0);
    m.issue(3'b011, 2'h1, 12'h005);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(rdat & 32'hff, 32'h02);
    wb(1'b1, 8'h00, 32'h23, rdat);
    m.write(2'h1, 12'h000, 8, 16'ha000, 2'h0);
    repeat (8) @(posedge clk_i);
    $display("test setup done");
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 4; i++) begin
        wb(1'b1, 8'h00, 32'((i / 2 + 2) << 4 | (i % 2) << 3 | k), rdat);
        rd_chk(9'h003, i / 2 + 2, 1 << k, 1'(i % 2));
      end
    // Low lane masked: only the high byte of column 3 changes
    wb(1'b1, 8'h00, 32'h20, rdat);
    m.write(2'h1, 12'h003, 1, 16'h5a77, 2'h1);
    repeat (4) @(posedge clk_i);
    m.issue(3'b101, 2'h1, 12'h003);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(dq_o), 32'h5a03);
    $display("test bursts done");
    wb(1'b1, 8'h00, 32'h22, rdat);
    m.issue(3'b101, 2'h1, 12'h000);
    repeat (2) @(posedge clk_i);
    m.set_cke(1'b0);
    for (int i = 3; i < 7; i++) begin
      @(posedge clk_i);
      if (i == 4) m.set_cke(1'b1);
      #1 chk(32'(dq_o), 32'ha000 + 32'(i < 6 ? 1 : 2));
    end
    $display("test suspend done");
    wb(1'b1, 8'h00, 32'h27, rdat);
    m.issue(3'b101, 2'h1, 12'h000);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(32'(rdat[4]), 32'h1);
    m.issue(3'b110, 2'h1, 12'h000);
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(32'(rdat[4]), 32'h0);
    wb(1'b1, 8'h00, 32'h20, rdat);
    m.issue(3'b101, 2'h1, 12'h400);
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(rdat & 32'hff, 32'h0);
    $display("test stop and precharge done");
    m.power_down();
    repeat (4) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(rdat & 32'hff, 32'h20);
    m.issue(3'b011, 2'h2, 12'h001);
    m.set_cke(1'b1);
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(rdat & 32'hff, 32'h0);
    cnt = rdat[31:16];
    m.issue(3'b001, 2'h0, 12'h000);
    repeat (3) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(32'(rdat[31:16]), 32'(cnt + 16'h1));
    m.self_refresh();
    repeat (1700) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(32'(rdat[6]), 32'h1);
    chk(32'(rdat[31:16] > cnt + 16'h1), 32'h1);
    m.set_cke(1'b1);
    repeat (6) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rdat); chk(rdat & 32'hff, 32'h0);
    $display("test low power done");
    wrap_up();
  end
endmodule : tb_sdram_clock_enable_burst_front_end
`default_nettype wire

// >>> design/sdram_front_end.sv
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R01] Inputs sampled only at rising clock edge
// [R02] Each edge advances burst counter and outputs
// [R03] Clock enable low freezes state next cycle
// [R04] Clock enable low, banks idle: low power
// [R05] Low-power exit via asynchronous clock enable
// [R06] Other inputs ignored in low-power states
// [R07] Controller opens row before read or write
// [R08] Four banks of 2M sixteen-bit words
// [R09] Burst from addressed column, programmed count
// [R10] Burst 1,2,4,8 or page; stop ends
// [R11] Sequential or interleaved burst order
// [R12] Auto-precharge closes row at burst end
// [R13] Auto-refresh and timed self-refresh supported
// [R14] Read latency two or three cycles
// [R15] Controller refreshes 4096 rows per 64ms

// ****************************************************************
// Write buffer
// ****************************************************************
module sdram_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;   // Storage words
    logic [AW-1:0]           wp;    // Write pointer
    logic [AW-1:0]           rp;    // Read pointer
    logic [AW:0]             cnt;   // Occupancy
  } fifo_t;
  fifo_t s, n;
  logic push, pop;

  // Honest flags straight from occupancy
  assign in_ready_o  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // Next state
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data_i;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : sdram_fifo

// ****************************************************************
// Device front end
// ****************************************************************
module sdram_front_end #(
  parameter int ROW_W = sdram_pkg::ROW_W,
  parameter int COL_W = sdram_pkg::COL_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [1:0]        ba_i,
  input  wire logic [ROW_W-1:0]  addr_i,
  input  wire logic [1:0]        dqm_i,
  input  wire logic [15:0]       dq_i,
  output logic [15:0]            dq_o,
  output logic                   dq_oe_o
);
  localparam int AW = sdram_pkg::BANK_W + ROW_W + COL_W;   // Flat word address
  localparam int FW = AW + 16 + 2;                          // Address, data, mask
  localparam int TW = 11;                                   // Self-refresh timer width
  localparam logic [TW-1:0] SREF_RELOAD = TW'(sdram_pkg::SREF_CYCLES - 1);

  typedef struct packed {
    logic [2:0]                 mode_bl;  // Burst length code
    logic                       mode_il;  // Interleaved order
    logic [2:0]                 mode_cl;  // Read latency
    logic                       ack;      // Bus answer
    logic [31:0]                rdata;    // Bus read data
    logic                       cke_q;    // Clock enable seen at last edge
    logic                       sync1;    // Wake-up synchroniser, first stage
    logic                       sync2;    // Wake-up synchroniser, second stage
    sdram_pkg::pwr_t            pwr;      // Power state
    logic [3:0]                 open;     // Banks with a row open
    logic [3:0][ROW_W-1:0]      rows;     // Open row per bank
    sdram_pkg::burst_t          bst;      // Burst kind
    logic [1:0]                 bbank;    // Burst bank
    logic [COL_W-1:0]           bcol;     // Start column
    logic [COL_W:0]             bcnt;     // Words done
    logic [COL_W:0]             blen;     // Words in burst
    logic                       bil;      // Order for this burst
    logic                       bap;      // Auto-precharge for this burst
    logic [15:0]                p0;       // Read pipe stage one
    logic                       pv0;
    logic [15:0]                p1;       // Read pipe stage two
    logic                       pv1;
    logic [15:0]                dq;       // Output register
    logic                       oe;
    logic [15:0]                ref_cnt;  // Refreshes performed
    logic [TW-1:0]              tmr;      // Self-refresh interval timer
  } state_t;
  state_t s, n;

  logic [15:0] mem [0:(1<<AW)-1];   // Four banks, 2M words each  [R08]
  sdram_pkg::cmd_t cmd;
  logic [COL_W-1:0] col;
  logic [AW-1:0] rd_adr;
  logic push_valid, push_ready, pop_valid, pop_ready;
  logic [FW-1:0] push_data, pop_data;

  // Pin pattern to command
  function automatic sdram_pkg::cmd_t decode_cmd(input logic cs, ras, cas, we);
    if (cs) return sdram_pkg::C_NOP;
    unique case ({ras, cas, we})
      3'h3:    return sdram_pkg::C_ACT;
      3'h5:    return sdram_pkg::C_RD;
      3'h4:    return sdram_pkg::C_WR;
      3'h6:    return sdram_pkg::C_BST;
      3'h2:    return sdram_pkg::C_PRE;
      3'h1:    return sdram_pkg::C_REF;
      default: return sdram_pkg::C_NOP;   // Mode set and no-op are not acted on
    endcase
  endfunction : decode_cmd

  // Burst length code to word count
  function automatic logic [COL_W:0] bl_words(input logic [2:0] code);
    if (code == sdram_pkg::BL_FULL) return (COL_W+1)'(1 << COL_W);   // [R10]
    return (COL_W+1)'(1 << code[1:0]);                                 // [R10]
  endfunction : bl_words

  // Column of word cnt inside the wrap block
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W:0] cnt,
                                                 input logic [COL_W:0] len,
                                                 input logic il);
    logic [COL_W-1:0] m;
    m = COL_W'(len - 1'b1);
    if (il) return (start & ~m) | ((start ^ cnt[COL_W-1:0]) & m);   // [R11]
    return (start & ~m) | ((start + cnt[COL_W-1:0]) & m);           // [R09]
  endfunction : burst_col

  assign cmd    = decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  assign col    = burst_col(s.bcol, s.bcnt, s.blen, s.bil);
  assign rd_adr = {s.bbank, s.rows[s.bbank], col};
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign dq_o     = s.dq;
  assign dq_oe_o  = s.oe;
  // Drain waits while a read burst owns the array port
  assign pop_ready = (s.bst != sdram_pkg::B_READ);

  // Next state
  always_comb begin
    n = s;
    push_valid = 1'b0;
    push_data  = '0;
    // Bus slave: one wait state, unmapped reads give zero
    n.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    if (n.ack) begin
      unique case (wb_adr_i)
        sdram_pkg::ADR_MODE:   n.rdata = {25'h0, s.mode_cl, s.mode_il, s.mode_bl};
        sdram_pkg::ADR_STATUS: n.rdata = {s.ref_cnt, 8'h0,
                                          (s.pwr == sdram_pkg::PWR_RUN) & ~s.cke_q,
                                          s.pwr == sdram_pkg::PWR_SELF,
                                          s.pwr == sdram_pkg::PWR_DOWN,
                                          s.bst != sdram_pkg::B_IDLE, s.open};
        default:               n.rdata = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == sdram_pkg::ADR_MODE) begin
        n.mode_bl = wb_dat_i[sdram_pkg::MODE_BL_LSB +: 3];
        n.mode_il = wb_dat_i[sdram_pkg::MODE_IL_BIT];
        n.mode_cl = wb_dat_i[sdram_pkg::MODE_CL_LSB +: 3];
      end
    end
    // Wake-up path; first stage feeds only the second
    n.sync1 = cke_i;
    n.sync2 = s.sync1;
    unique case (s.pwr)
      sdram_pkg::PWR_RUN: begin
        n.cke_q = cke_i;                                   // [R01]
        // Internal clock runs only if enable was high last edge
        if (s.cke_q) begin                                 // [R03]
          // Read pipe and output registers
          n.p1  = s.p0;                                    // [R02]
          n.pv1 = s.pv0;
          n.pv0 = 1'b0;
          if (s.mode_cl == sdram_pkg::CL_THREE) begin      // [R14]
            n.dq = s.p1;
            n.oe = s.pv1;
          end else begin
            n.dq = s.p0;
            n.oe = s.pv0;
          end
          // Burst in progress
          if (s.bst == sdram_pkg::B_READ) begin
            n.p0  = mem[rd_adr];
            n.pv0 = 1'b1;
          end
          if (s.bst == sdram_pkg::B_WRITE) begin
            push_valid = 1'b1;
            push_data  = {rd_adr, dq_i, dqm_i};
          end
          // A full buffer holds the write burst in place
          if (s.bst != sdram_pkg::B_IDLE &&
              (s.bst != sdram_pkg::B_WRITE || push_ready)) begin
            n.bcnt = s.bcnt + 1'b1;                        // [R02]
            if (s.bcnt == s.blen - 1'b1) begin             // [R09]
              n.bst = sdram_pkg::B_IDLE;
              if (s.bap) n.open[s.bbank] = 1'b0;          // [R12]
            end
          end
          // Commands; a new access cuts the running burst short
          unique case (cmd)
            sdram_pkg::C_ACT: begin
              n.open[ba_i] = 1'b1;
              n.rows[ba_i] = addr_i;
            end
            sdram_pkg::C_PRE: begin
              if (addr_i[sdram_pkg::AP_BIT]) n.open = 4'h0;
              else n.open[ba_i] = 1'b0;
            end
            sdram_pkg::C_RD, sdram_pkg::C_WR: begin
              // Closed bank: access dropped, controller must open it first
              if (s.open[ba_i]) begin                      // [R07]
                n.bst   = (cmd == sdram_pkg::C_RD) ? sdram_pkg::B_READ : sdram_pkg::B_WRITE;
                n.bbank = ba_i;
                n.bcol  = addr_i[COL_W-1:0];               // [R09]
                n.bcnt  = '0;
                n.blen  = bl_words(s.mode_bl);             // [R10]
                n.bil   = s.mode_il;                       // [R11]
                n.bap   = addr_i[sdram_pkg::AP_BIT];       // [R12]
              end
            end
            sdram_pkg::C_BST: begin
              n.bst = sdram_pkg::B_IDLE;                   // [R10]
            end
            sdram_pkg::C_REF: begin
              if (cke_i && s.open == 4'h0) n.ref_cnt = s.ref_cnt + 1'b1;   // [R13]
            end
            default: ;
          endcase
          // Low-power entry needs every bank idle
          if (!cke_i && s.open == 4'h0 && s.bst == sdram_pkg::B_IDLE) begin   // [R04]
            // Synchroniser still holds the old high level; drop it so entry cannot wake at once
            if (cmd == sdram_pkg::C_REF) begin
              n.pwr   = sdram_pkg::PWR_SELF;
              n.tmr   = SREF_RELOAD;
              n.sync2 = 1'b0;                              // [R05]
            end else if (cmd == sdram_pkg::C_NOP) begin
              n.pwr   = sdram_pkg::PWR_DOWN;
              n.sync2 = 1'b0;                              // [R05]
            end
          end
        end
      end
      default: begin
        // Receivers off: only the synchronised enable is watched   [R06]
        n.cke_q = 1'b0;
        if (s.pwr == sdram_pkg::PWR_SELF) begin
          n.tmr = s.tmr - 1'b1;
          if (s.tmr == '0) begin
            n.tmr = SREF_RELOAD;
            n.ref_cnt = s.ref_cnt + 1'b1;                 // [R13]
          end
        end
        if (s.sync2) begin                                 // [R05]
          n.pwr   = sdram_pkg::PWR_RUN;
          n.cke_q = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.mode_bl <= sdram_pkg::MODE_BL_RST;
      s.mode_cl <= sdram_pkg::MODE_CL_RST;
      s.cke_q   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Array write from the buffer, masked lanes kept
  always_ff @(posedge clk_i) begin
    if (pop_valid && pop_ready) begin
      if (!pop_data[0]) mem[pop_data[FW-1 -: AW]][7:0]  <= pop_data[9:2];
      if (!pop_data[1]) mem[pop_data[FW-1 -: AW]][15:8] <= pop_data[17:10];
    end
  end

  sdram_fifo #(.W(FW), .DEPTH(sdram_pkg::FIFO_DEPTH)) u_wbuf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic run_now, rd_take;
  assign run_now = (s.pwr == sdram_pkg::PWR_RUN) && s.cke_q;
  assign rd_take = run_now && cmd == sdram_pkg::C_RD && s.open[ba_i];

  AST_SUSPEND_FREEZE: assert property ( // R03
    (s.pwr == sdram_pkg::PWR_RUN && !s.cke_q) |=> $stable(s.bcnt) && $stable(dq_o))
    else $error("state moved while clock suspended");
  AST_BURST_STEP: assert property ( // R02
    (run_now && s.bst == sdram_pkg::B_READ && s.bcnt != s.blen - 1'b1 && cmd == sdram_pkg::C_NOP)
    |=> s.bcnt == $past(s.bcnt) + 1'b1)
    else $error("burst counter did not advance");
  AST_LP_IDLE: assert property ( // R04
    (s.pwr != sdram_pkg::PWR_RUN) |-> s.open == 4'h0 && s.bst == sdram_pkg::B_IDLE)
    else $error("low power with a bank open");
  AST_LP_DEAF: assert property ( // R06
    (s.pwr == sdram_pkg::PWR_DOWN && cmd == sdram_pkg::C_ACT) |=> s.open == 4'h0)
    else $error("command acted on in power-down");
  AST_WAKE: assert property ( // R05
    (s.pwr != sdram_pkg::PWR_RUN && s.sync2) |=> s.pwr == sdram_pkg::PWR_RUN)
    else $error("no exit after enable returned");
  AST_CL2: assert property ( // R14
    (rd_take && s.mode_cl != sdram_pkg::CL_THREE) ##1 run_now[*2] |=> !$past(dq_oe_o) && dq_oe_o)
    else $error("latency two output misplaced");
  AST_CL3: assert property ( // R14
    (rd_take && s.mode_cl == sdram_pkg::CL_THREE) ##1 run_now[*3] |=> dq_oe_o && !$past(dq_oe_o))
    else $error("latency three output misplaced");
  AST_AUTOPRE: assert property ( // R12
    (run_now && s.bst == sdram_pkg::B_READ && s.bap && s.bcnt == s.blen - 1'b1
     && cmd == sdram_pkg::C_NOP) |=> !s.open[$past(s.bbank)])
    else $error("row left open after auto-precharge burst");
  AST_SREF_TICK: assert property ( // R13
    (s.pwr == sdram_pkg::PWR_SELF && s.tmr == '0) |=> s.ref_cnt == $past(s.ref_cnt) + 1'b1)
    else $error("self-refresh interval missed");
  AST_STOP: assert property ( // R10
    (run_now && cmd == sdram_pkg::C_BST) |=> s.bst == sdram_pkg::B_IDLE)
    else $error("burst stop ignored");
  AST_WB_ACK: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single pulse");

  COV_CL3_READ: cover property (rd_take && s.mode_cl == sdram_pkg::CL_THREE ##[3:6] dq_oe_o);
  COV_PDOWN:    cover property (s.pwr == sdram_pkg::PWR_DOWN ##[1:20] s.pwr == sdram_pkg::PWR_RUN);
  COV_SREF:     cover property (s.pwr == sdram_pkg::PWR_SELF && s.tmr == '0);
  COV_FULL:     cover property (push_valid && !push_ready);
endmodule : sdram_front_end
`default_nettype wire

// >>> design/sdram_pkg.sv
`default_nettype none
package sdram_pkg;
  // ****************************************************************
  // Array geometry defaults
  // ****************************************************************
  localparam int BANK_W = 2;                       // Four banks
  localparam int ROW_W  = 12;                      // 4096 rows per bank
  localparam int COL_W  = 9;                       // 512 columns, 2M words per bank
  localparam int DATA_W = 16;                      // Word width
  localparam int FIFO_DEPTH = 16;                  // Write-path buffer depth
  localparam int AP_BIT = 10;                      // Address bit that asks for auto-precharge

  // ****************************************************************
  // Register map, byte offsets on the bus
  // ****************************************************************
  localparam logic [7:0] ADR_MODE   = 8'h00;       // Burst and latency setup
  localparam logic [7:0] ADR_STATUS = 8'h04;       // Live state, read only
  localparam int MODE_BL_LSB = 0;                  // Burst length code, 3 bits
  localparam int MODE_IL_BIT = 3;                  // 1 = interleaved order
  localparam int MODE_CL_LSB = 4;                  // Read latency, 3 bits
  localparam logic [2:0] MODE_BL_RST = 3'h0;       // One word after reset
  localparam logic [2:0] MODE_CL_RST = 3'h2;       // Latency two after reset
  localparam logic [2:0] BL_FULL     = 3'h7;       // Full page code
  localparam logic [2:0] CL_THREE    = 3'h3;       // Latency three code
  localparam int ST_OPEN_LSB = 0;                  // Open-bank bits, 4 wide
  localparam int ST_BUSY_BIT = 4;                  // Burst running
  localparam int ST_PD_BIT   = 5;                  // Power-down
  localparam int ST_SR_BIT   = 6;                  // Self-refresh
  localparam int ST_SUSP_BIT = 7;                  // Clock suspended
  localparam int ST_REF_LSB  = 16;                 // Refresh count, 16 wide

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 10;
  localparam int REFRESH_WINDOW_NS = 64000000;     // 64 ms
  localparam int REFRESH_ROWS      = 4096;
  localparam int SREF_CYCLES = REFRESH_WINDOW_NS / REFRESH_ROWS / CLK_PERIOD_NS;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {PWR_RUN = 2'h0, PWR_DOWN = 2'h1, PWR_SELF = 2'h2} pwr_t;
  typedef enum logic [1:0] {B_IDLE = 2'h0, B_READ = 2'h1, B_WRITE = 2'h2} burst_t;
  typedef enum logic [2:0] {C_NOP = 3'h0, C_ACT = 3'h1, C_RD = 3'h3, C_WR = 3'h2,
                            C_PRE = 3'h6, C_REF = 3'h7, C_BST = 3'h5} cmd_t;
endpackage : sdram_pkg
`default_nettype wire
